// ===== ebt_pkg.sv
// Purpose: shared constants and types of the dual 8-bit timer block
// Assumes: 32-bit register bus, one aligned word per register
// Notes: channel 1 registers sit one stride above channel 0
package ebt_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int CH_BIT = 4;
  localparam logic [2:0] ADDR_TOP = 3'h0;
  localparam logic [3:0] OFS_CLKSEL = 4'h0;
  localparam logic [3:0] OFS_CMP = 4'h4;
  localparam logic [3:0] OFS_MODE = 4'h8;
  localparam logic [3:0] OFS_COUNT = 4'hC;

  // ----------------------------------------------------------------
  // mode control fields
  // ----------------------------------------------------------------
  localparam int MB_RUN = 7;
  localparam int MB_PWM = 6;
  localparam int MB_CASC = 4;
  localparam int MB_SET = 3;
  localparam int MB_CLR = 2;
  localparam int MB_INV = 1;
  localparam int MB_OE = 0;
  localparam logic [1:0] PRESET_CLR = 2'h1;
  localparam logic [1:0] PRESET_SET = 2'h2;

  // ----------------------------------------------------------------
  // reset values, count clock codes, counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_SEL = 3'h0;
  localparam logic [2:0] SEL_FALL = 3'h0;
  localparam logic [2:0] SEL_RISE = 3'h1;
  localparam logic [2:0] SEL_DIV1 = 3'h2;
  localparam logic [2:0] SEL_DIV2 = 3'h3;
  localparam logic [2:0] SEL_DIV4 = 3'h4;
  localparam logic [2:0] SEL_DIV64 = 3'h5;
  localparam logic [2:0] SEL_DIV256 = 3'h6;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // write path states
  typedef enum logic {WR_IDLE = 1'b0, WR_RESP = 1'b1} ebt_wr_t;

endpackage

// ===== ebt_tick_if.sv
// Purpose: count clock select and tick between top and tick generator
// Assumes: one clock domain
// Notes: tick is a one-cycle qualifier, not a clock
`timescale 1ns/1ps
interface ebt_tick_if;
  logic [2:0] sel;
  logic evt;
  logic tick;
  modport gen (input sel, input evt, output tick);
  modport cons (output sel, output evt, input tick);
endinterface

// ===== ebt_tick_gen.sv
// Purpose: count tick from prescaled clock or event pin edge
// Assumes: event pin synchronous to clk_i
// Notes: unused select code gives no tick
`timescale 1ns/1ps
module ebt_tick_gen (
  input wire logic clk_i,
  input wire logic reset_i,
  ebt_tick_if.gen t
);

  logic evt_prev_r;
  logic [7:0] pre_r;

  // previous pin level for edge detection
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      evt_prev_r <= 1'b0;
    else
      evt_prev_r <= t.evt;
  end

  // free-running prescaler
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      pre_r <= ebt_pkg::RST_BYTE;
    else
      pre_r <= pre_r + ebt_pkg::CNT_ONE;
  end

  // tick select
  always_comb
  begin
    case (t.sel)
      ebt_pkg::SEL_FALL: t.tick = evt_prev_r & ~t.evt;
      ebt_pkg::SEL_RISE: t.tick = ~evt_prev_r & t.evt;
      ebt_pkg::SEL_DIV1: t.tick = 1'b1;
      ebt_pkg::SEL_DIV2: t.tick = pre_r[0];
      ebt_pkg::SEL_DIV4: t.tick = &pre_r[1:0];
      ebt_pkg::SEL_DIV64: t.tick = &pre_r[5:0];
      ebt_pkg::SEL_DIV256: t.tick = &pre_r;
      default: t.tick = 1'b0;
    endcase
  end

  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_rise_tick;
    (t.sel == ebt_pkg::SEL_RISE) && t.evt ##1
    (t.sel == ebt_pkg::SEL_RISE) && !t.evt ##1
    (t.sel == ebt_pkg::SEL_RISE) && t.evt |-> t.tick;
  endproperty
  a_rise_tick: assert property (p_rise_tick)
    else $error("rising edge gave no tick");

  property p_fall_tick;
    (t.sel == ebt_pkg::SEL_FALL) && (evt_prev_r == t.evt) |-> !t.tick;
  endproperty
  a_fall_tick: assert property (p_fall_tick)
    else $error("tick without an edge");

endmodule

// ===== ebt_timer.sv
// Purpose: two 8-bit timer/event counters behind an AXI4-Lite slave
// Assumes: single clock, synchronous active-high reset
// Notes: channel 1 may join channel 0 as a 16-bit counter
// Notes on behaviour
// - interval match clears counter, interrupts, continues
// - count enable starts; clearing it stops
// - event mode counts each valid pin edge
// - clock select 0 falling, 1 rising edge
// - event interrupt after N+1 edges, counter cleared
// - square wave: match toggles output when invert bit set, interrupts, clears
// - mode bit selects PWM; invert bit sets level
// - PWM output inactive until first overflow
// - overflow drives active, match drives inactive
// - PWM period 256 counts, width N counts
// - disabling count forces PWM output inactive
// - new PWM compare takes effect after overflow
// - compare read returns newly written value
// - cascade bit joins channels into 16 bits
// - cascade match interrupts channel 0, clears counter
// - cascade uses channel 0 clock; channel 1 clock select unused
// - preset bits clear or set output; read zero
// - output disabled holds timer pin low
// - count enable low clears and holds counter
`timescale 1ns/1ps
module ebt_timer (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [1:0] event_input_pin_i,
  output logic [1:0] timer_output_pin_o,
  output logic low_channel_interrupt_o,
  output logic high_channel_interrupt_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic aw_rdy_r, w_rdy_r, aw_got_r, w_got_r, bvalid_r;
  logic ar_rdy_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, wd_r;
  logic [7:0] wa_r;
  logic [3:0] ws_r;
  ebt_pkg::ebt_wr_t wr_st_r;
  logic do_write, wen;
  logic [2:0] sel_r [2];
  logic [7:0] cmp_r [2];
  logic [7:0] cnt_r [2];
  logic [7:0] stage_r [2];
  logic [7:0] act_r [2];
  logic [7:0] inc [2];
  logic [1:0] run_r, pwm_r, inv_r, oe_r, ff_r, lvl_r, out_r, irq_r;
  logic casc_r;
  logic [1:0] tk, m8, ovf, phit, hit, tog;
  logic m16;

  ebt_tick_if tif0 ();
  ebt_tick_if tif1 ();

  // address inside the register window
  function automatic logic reg_ok(input logic [7:0] a);
    reg_ok = (a[7:5] == ebt_pkg::ADDR_TOP);
  endfunction

  // read data of one register
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic ch;
    ch = a[ebt_pkg::CH_BIT];
    case (a[3:0])
      ebt_pkg::OFS_CLKSEL: rd_word = {29'h0, sel_r[ch]};
      ebt_pkg::OFS_CMP: rd_word = {24'h0, cmp_r[ch]};
      ebt_pkg::OFS_MODE: rd_word = {24'h0, run_r[ch], pwm_r[ch], 1'b0,
        casc_r & ch, 2'b00, inv_r[ch], oe_r[ch]};
      ebt_pkg::OFS_COUNT: rd_word = {24'h0, cnt_r[ch]};
      default: rd_word = 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // count tick sources
  // ----------------------------------------------------------------
  assign tif0.sel = sel_r[0];
  assign tif0.evt = event_input_pin_i[0];
  assign tif1.sel = sel_r[1];
  assign tif1.evt = event_input_pin_i[1];

  ebt_tick_gen u_tick0 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .t(tif0)
  );

  ebt_tick_gen u_tick1 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .t(tif1)
  );

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  assign do_write = (wr_st_r == ebt_pkg::WR_IDLE) & aw_got_r & w_got_r;
  assign wen = do_write & ws_r[0] & reg_ok(wa_r);

  // write address capture
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      aw_rdy_r <= 1'b0;
      aw_got_r <= 1'b0;
      wa_r <= ebt_pkg::RST_BYTE;
    end
    else if (aw_rdy_r && s_axi_awvalid_i)
    begin
      aw_rdy_r <= 1'b0;
      aw_got_r <= 1'b1;
      wa_r <= s_axi_awaddr_i;
    end
    else if (do_write)
      aw_got_r <= 1'b0;
    else
      aw_rdy_r <= !aw_got_r && (wr_st_r == ebt_pkg::WR_IDLE);
  end

  // write data capture
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      w_rdy_r <= 1'b0;
      w_got_r <= 1'b0;
      wd_r <= 32'h0000_0000;
      ws_r <= 4'h0;
    end
    else if (w_rdy_r && s_axi_wvalid_i)
    begin
      w_rdy_r <= 1'b0;
      w_got_r <= 1'b1;
      wd_r <= s_axi_wdata_i;
      ws_r <= s_axi_wstrb_i;
    end
    else if (do_write)
      w_got_r <= 1'b0;
    else
      w_rdy_r <= !w_got_r && (wr_st_r == ebt_pkg::WR_IDLE);
  end

  // write response
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wr_st_r <= ebt_pkg::WR_IDLE;
      bvalid_r <= 1'b0;
      bresp_r <= ebt_pkg::RESP_OKAY;
    end
    else
    begin
      case (wr_st_r)
        ebt_pkg::WR_IDLE:
          if (do_write)
          begin
            wr_st_r <= ebt_pkg::WR_RESP;
            bvalid_r <= 1'b1;
            bresp_r <= reg_ok(wa_r) ? ebt_pkg::RESP_OKAY
                                    : ebt_pkg::RESP_DECERR;
          end
        ebt_pkg::WR_RESP:
          if (s_axi_bready_i)
          begin
            wr_st_r <= ebt_pkg::WR_IDLE;
            bvalid_r <= 1'b0;
          end
        default:
        begin
          wr_st_r <= ebt_pkg::WR_IDLE;
          bvalid_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= ebt_pkg::RESP_OKAY;
    end
    else if (ar_rdy_r && s_axi_arvalid_i)
    begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= reg_ok(s_axi_araddr_i) ? rd_word(s_axi_araddr_i)
                                        : 32'h0000_0000;
      rresp_r <= reg_ok(s_axi_araddr_i) ? ebt_pkg::RESP_OKAY
                                        : ebt_pkg::RESP_DECERR;
    end
    else
    begin
      if (rvalid_r && s_axi_rready_i)
        rvalid_r <= 1'b0;
      ar_rdy_r <= !rvalid_r;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < 2; i++)
      begin
        sel_r[i] <= ebt_pkg::RST_SEL;
        cmp_r[i] <= ebt_pkg::RST_BYTE;
      end
      run_r <= 2'b00;
      pwm_r <= 2'b00;
      inv_r <= 2'b00;
      oe_r <= 2'b00;
      casc_r <= 1'b0;
    end
    else if (wen)
    begin
      case (wa_r[3:0])
        ebt_pkg::OFS_CLKSEL: sel_r[wa_r[4]] <= wd_r[2:0];
        ebt_pkg::OFS_CMP: cmp_r[wa_r[4]] <= wd_r[7:0];
        ebt_pkg::OFS_MODE:
        begin
          run_r[wa_r[4]] <= wd_r[ebt_pkg::MB_RUN];
          pwm_r[wa_r[4]] <= wd_r[ebt_pkg::MB_PWM];
          inv_r[wa_r[4]] <= wd_r[ebt_pkg::MB_INV];
          oe_r[wa_r[4]] <= wd_r[ebt_pkg::MB_OE];
          if (wa_r[4])
            casc_r <= wd_r[ebt_pkg::MB_CASC];
        end
        default: casc_r <= casc_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // compare and tick decode
  // ----------------------------------------------------------------
  always_comb
  begin
    tk[0] = run_r[0] & tif0.tick;
    tk[1] = run_r[1] & !casc_r & tif1.tick;
    for (int i = 0; i < 2; i++)
    begin
      inc[i] = cnt_r[i] + ebt_pkg::CNT_ONE;
      m8[i] = (cnt_r[i] == cmp_r[i]);
      ovf[i] = tk[i] & pwm_r[i] & (cnt_r[i] == ebt_pkg::CNT_MAX);
      phit[i] = tk[i] & pwm_r[i] & (inc[i] == act_r[i]);
    end
    m16 = ({cnt_r[1], cnt_r[0]} == {cmp_r[1], cmp_r[0]});
    hit[0] = tk[0] & (casc_r ? m16 : (pwm_r[0] ? phit[0] : m8[0]));
    hit[1] = tk[1] & (pwm_r[1] ? phit[1] : m8[1]);
    for (int i = 0; i < 2; i++)
      tog[i] = hit[i] & !pwm_r[i] & inv_r[i];
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cnt_r[0] <= ebt_pkg::CNT_ZERO;
      cnt_r[1] <= ebt_pkg::CNT_ZERO;
    end
    else
    begin
      // low channel, also the cascade low byte
      if (!run_r[0])
        cnt_r[0] <= ebt_pkg::CNT_ZERO;
      else if (tk[0])
        cnt_r[0] <= (hit[0] && !pwm_r[0]) ? ebt_pkg::CNT_ZERO
                                          : inc[0];
      // high channel
      if (!run_r[1])
        cnt_r[1] <= ebt_pkg::CNT_ZERO;
      else if (casc_r)
      begin
        if (tk[0] && m16)
          cnt_r[1] <= ebt_pkg::CNT_ZERO;
        else if (tk[0] && cnt_r[0] == ebt_pkg::CNT_MAX)
          cnt_r[1] <= inc[1];
      end
      else if (tk[1])
        cnt_r[1] <= (hit[1] && !pwm_r[1]) ? ebt_pkg::CNT_ZERO
                                          : inc[1];
    end
  end

  // pwm compare staging: stage loads one tick before overflow, active copy at overflow
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (reset_i)
      begin
        stage_r[i] <= ebt_pkg::RST_BYTE;
        act_r[i] <= ebt_pkg::RST_BYTE;
      end
      else if (!run_r[i] || !pwm_r[i])
      begin
        stage_r[i] <= cmp_r[i];
        act_r[i] <= cmp_r[i];
      end
      else
      begin
        if (tk[i] && inc[i] == ebt_pkg::CNT_MAX)
          stage_r[i] <= cmp_r[i];
        if (ovf[i])
          act_r[i] <= stage_r[i];
      end
    end
  end

  // pwm level: active from overflow to match
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (reset_i)
        lvl_r[i] <= 1'b0;
      else if (!run_r[i] || !pwm_r[i])
        lvl_r[i] <= 1'b0;
      else if (ovf[i])
        lvl_r[i] <= (stage_r[i] != ebt_pkg::CNT_ZERO);
      else if (phit[i])
        lvl_r[i] <= 1'b0;
    end
  end

  // timer output flip-flop: preset on write, toggle on match when invert bit set
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (reset_i)
        ff_r[i] <= 1'b0;
      else if (wen && wa_r[3:0] == ebt_pkg::OFS_MODE &&
               wa_r[4] == 1'(i) && !wd_r[ebt_pkg::MB_PWM])
      begin
        case (wd_r[ebt_pkg::MB_SET:ebt_pkg::MB_CLR])
          ebt_pkg::PRESET_CLR: ff_r[i] <= 1'b0;
          ebt_pkg::PRESET_SET: ff_r[i] <= 1'b1;
          default: ff_r[i] <= ff_r[i];
        endcase
      end
      else if (tog[i])
        ff_r[i] <= !ff_r[i];
    end
  end

  // pins and interrupt pulses
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (reset_i)
      begin
        out_r[i] <= 1'b0;
        irq_r[i] <= 1'b0;
      end
      else
      begin
        out_r[i] <= oe_r[i] & (pwm_r[i] ? (lvl_r[i] ^ inv_r[i])
                                        : ff_r[i]);
        irq_r[i] <= hit[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready_o = aw_rdy_r;
  assign s_axi_wready_o = w_rdy_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = ar_rdy_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;
  assign timer_output_pin_o = out_r;
  assign low_channel_interrupt_o = irq_r[0];
  assign high_channel_interrupt_o = irq_r[1];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_stop_hold;
    !run_r[0] |=> (cnt_r[0] == ebt_pkg::CNT_ZERO);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stopped counter not zero");

  property p_count_step;
    tk[0] && !casc_r && !pwm_r[0] && !m8[0] && run_r[0]
      |=> cnt_r[0] == 8'($past(cnt_r[0]) + ebt_pkg::CNT_ONE);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not advance on tick");

  property p_intv_match;
    tk[0] && !casc_r && !pwm_r[0] && m8[0]
      |=> (cnt_r[0] == ebt_pkg::CNT_ZERO) && irq_r[0];
  endproperty
  a_intv_match: assert property (p_intv_match)
    else $error("match did not clear and interrupt");

  property p_sq_toggle;
    tog[0] && !wen |=> ff_r[0] != $past(ff_r[0]);
  endproperty
  a_sq_toggle: assert property (p_sq_toggle)
    else $error("square wave flip-flop did not toggle");

  sequence s_pwm_ovf;
    ovf[0] && run_r[0] && (stage_r[0] != ebt_pkg::CNT_ZERO);
  endsequence
  sequence s_pwm_active;
    lvl_r[0] ##0 (act_r[0] == $past(stage_r[0]));
  endsequence
  property p_pwm_ovf;
    s_pwm_ovf |=> s_pwm_active;
  endproperty
  a_pwm_ovf: assert property (p_pwm_ovf)
    else $error("overflow did not reload and go active");

  property p_pwm_hit;
    phit[0] && !ovf[0] |=> !lvl_r[0] && irq_r[0];
  endproperty
  a_pwm_hit: assert property (p_pwm_hit)
    else $error("pwm match did not go inactive");

  property p_pwm_stop;
    (pwm_r[0] && oe_r[0] && !run_r[0]) [*2]
      |=> out_r[0] == $past(inv_r[0]);
  endproperty
  a_pwm_stop: assert property (p_pwm_stop)
    else $error("stopped pwm output not inactive");

  property p_oe_low;
    !oe_r[0] |=> !out_r[0];
  endproperty
  a_oe_low: assert property (p_oe_low)
    else $error("disabled output not low");

  property p_casc_match;
    tk[0] && casc_r && m16 && run_r[1] |=> irq_r[0] && !irq_r[1] &&
      ({cnt_r[1], cnt_r[0]} == {ebt_pkg::CNT_ZERO, ebt_pkg::CNT_ZERO});
  endproperty
  a_casc_match: assert property (p_casc_match)
    else $error("cascade match did not clear");

  property p_casc_carry;
    tk[0] && casc_r && run_r[1] && !m16 &&
      (cnt_r[0] == ebt_pkg::CNT_MAX)
      |=> cnt_r[1] == 8'($past(cnt_r[1]) + ebt_pkg::CNT_ONE);
  endproperty
  a_casc_carry: assert property (p_casc_carry)
    else $error("high byte did not carry");

  property p_preset_set;
    wen && !wa_r[4] && (wa_r[3:0] == ebt_pkg::OFS_MODE) &&
      !wd_r[ebt_pkg::MB_PWM] &&
      (wd_r[ebt_pkg::MB_SET:ebt_pkg::MB_CLR] == ebt_pkg::PRESET_SET)
      |=> ff_r[0];
  endproperty
  a_preset_set: assert property (p_preset_set)
    else $error("preset did not set flip-flop");

endmodule

// ===== ebt_evt_src.sv
// Purpose: event pulse source standing on the timer event pins
// Assumes: pins are sampled on clk_i by the timer
// Notes: idle low; each pulse gives one rising and one falling edge
`timescale 1ns/1ps
module ebt_evt_src (
  input wire logic clk_i,
  output logic [1:0] pin_o
);
  initial pin_o = 2'h0;
  // ----------------------------------------------------------------
  // pulse train, two cycles high and three low per event
  // ----------------------------------------------------------------
  task automatic pulse(input int ch, input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      pin_o[ch] <= 1'h1;
      repeat (2) @(posedge clk_i);
      pin_o[ch] <= 1'h0;
      repeat (2) @(posedge clk_i);
    end
  endtask
  // single level change, held two cycles
  task automatic level(input int ch, input logic v);
    @(posedge clk_i);
    pin_o[ch] <= v;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// ===== test_ebt_timer.sv
// Purpose: self-checking bench for the dual 8-bit timer
// Assumes: AXI4-Lite master driving on rising edges
// Notes: compare values drawn from a fixed xorshift seed
`timescale 1ns/1ps
module test_ebt_timer;
  localparam logic [3:0] CS = ebt_pkg::OFS_CLKSEL;
  localparam logic [3:0] CP = ebt_pkg::OFS_CMP;
  localparam logic [3:0] MD = ebt_pkg::OFS_MODE;
  localparam logic [3:0] CT = ebt_pkg::OFS_COUNT;
  logic clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h00000000;
  logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
  logic awr, wr_r, bv, arr, rv, lint, hint;
  logic [1:0] bresp, rresp, evt, pin;
  logic [31:0] rdata;
  logic [1:0] wres;
  logic [31:0] seed = 32'h00004EA4;
  int failures = 0, num_checks = 0, cyc = 0, nlo = 0, nhi = 0;

  ebt_timer uut (.clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_r), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .event_input_pin_i(evt),
    .timer_output_pin_o(pin), .low_channel_interrupt_o(lint),
    .high_channel_interrupt_o(hint));
  ebt_evt_src src (.clk_i(clk_i), .pin_o(evt));

  always #25 clk_i = ~clk_i;

  // interrupt tally and hang guard
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (lint === 1'h1) nlo <= nlo + 1;
    if (hint === 1'h1) nhi <= nhi + 1;
    if (cyc == 40000)
    begin
      failures++;
      conclude();
    end
  end

  // xorshift source of compare values
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] ad(input int ch, input logic [3:0] o);
    return {ebt_pkg::ADDR_TOP, ch[0], o};
  endfunction

  // count clocks per tick of each prescaler select, fastest first
  function automatic int dv(input int k);
    case (k)
      0: return 1;
      1: return 2;
      2: return 4;
      3: return 64;
      default: return 256;
    endcase
  endfunction

  function automatic logic mon(input int k);
    logic [3:0] m;
    m = {pin, hint, lint};
    return m[k];
  endfunction

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  // bus write: address and data offered together, each released when taken
  task automatic wa(input logic [7:0] a, input logic [7:0] d);
    logic done;
    done = 1'h0;
    @(posedge clk_i);
    awa <= a;
    wd <= {24'h000000, d};
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    while (!done)
    begin
      @(posedge clk_i);
      if (awv && awr === 1'h1) awv <= 1'h0;
      if (wv && wr_r === 1'h1) wv <= 1'h0;
      if (bv === 1'h1)
      begin
        done = 1'h1;
        wres = bresp;
        br <= 1'h0;
      end
    end
  endtask

  task automatic wr(input int ch, input logic [3:0] o, input logic [7:0] d);
    wa(ad(ch, o), d);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic done;
    done = 1'h0;
    @(posedge clk_i);
    ara <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    while (!done)
    begin
      @(posedge clk_i);
      if (arv && arr === 1'h1) arv <= 1'h0;
      if (rv === 1'h1)
      begin
        done = 1'h1;
        d = rdata;
        r = rresp;
        rr <= 1'h0;
      end
    end
  endtask

  task automatic rchk(input string s, input int ch, input logic [3:0] o,
                      input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(ad(ch, o), d, r);
    chk(s, e, d);
  endtask

  // length of the next whole run of value v on monitor bit k
  task automatic span(input int k, input logic v, output int n);
    n = 0;
    while (mon(k) === v) @(negedge clk_i);
    while (mon(k) !== v) @(negedge clk_i);
    while (mon(k) === v)
    begin
      n++;
      @(negedge clk_i);
    end
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    int n, m, g, b;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'h0;
    // reset value and an unmapped address
    rchk("mode reset", 0, MD, 32'h0);
    rd(8'hE0, d, r);
    chk("decerr", 32'(ebt_pkg::RESP_DECERR), 32'(r));
    wa(8'hE0, 8'h07);
    chk("write decerr", 32'(ebt_pkg::RESP_DECERR), 32'(wres));
    rchk("write ignored", 0, CS, 32'h0);
    // interval timer on each prescaler, slowest first, then stop
    for (int k = 4; k >= 0; k--)
    begin
      n = 2 + rnd() % 16;
      wr(0, CS, {5'h00, 3'(ebt_pkg::SEL_DIV1 + k)});
      chk("bresp okay", 32'(ebt_pkg::RESP_OKAY), 32'(wres));
      wr(0, CP, n[7:0]);
      wr(0, MD, 8'h80);
      span(0, 1'h0, g);
      chk("interval gap", dv(k) * (n + 1) - 1, g);
      wr(0, MD, 8'h00);
    end
    repeat (2) @(posedge clk_i);
    g = nlo;
    repeat (20) @(posedge clk_i);
    chk("stop irq", g, nlo);
    rchk("stop count", 0, CT, 32'h0);
    // event counting on falling then rising edges
    for (int e = 0; e < 2; e++)
    begin
      n = 1 + rnd() % 6;
      wr(1, CS, {5'h00, e ? ebt_pkg::SEL_RISE : ebt_pkg::SEL_FALL});
      wr(1, CP, n[7:0]);
      wr(1, MD, 8'h80);
      src.pulse(1, n - 1);
      src.level(1, 1'h1);
      rchk("event edge", 1, CT, n - 1 + e);
      src.level(1, 1'h0);
      rchk("event count", 1, CT, n);
      chk("ch1 pin", 0, pin[1]);
      g = nhi;
      src.pulse(1, 1);
      repeat (3) @(posedge clk_i);
      chk("event irq", g + 1, nhi);
      rchk("event clear", 1, CT, 32'h0);
      wr(1, MD, 8'h00);
    end
    // square wave from preset high
    n = 2 + rnd() % 16;
    wr(0, CP, n[7:0]);
    wr(0, MD, 8'h0B);
    rchk("preset read", 0, MD, 32'h03);
    chk("preset high", 1, pin[0]);
    wr(0, MD, 8'h8B);
    span(2, 1'h1, g);
    chk("square half", n + 1, g);
    wr(0, MD, 8'h0A);
    repeat (2) @(negedge clk_i);
    chk("output off", 0, pin[0]);
    // pwm with both active levels and a compare reload
    for (int v = 0; v < 2; v++)
    begin
      n = 1 + rnd() % 254;
      m = 1 + rnd() % 254;
      b = 8'h41 | (v << 1);
      wr(0, CP, n[7:0]);
      wr(0, MD, b[7:0]);
      wr(0, MD, b[7:0] | 8'h80);
      repeat (100) @(negedge clk_i);
      chk("pwm idle", v, pin[0]);
      span(2, v[0], g);
      chk("pwm rest", 256 - n, g);
      span(2, !v[0], g);
      chk("pwm width", n, g);
      wr(0, CP, m[7:0]);
      rchk("reload read", 0, CP, m);
      span(2, !v[0], g);
      span(2, !v[0], g);
      chk("reload width", m, g);
      wr(0, MD, b[7:0]);
      repeat (3) @(negedge clk_i);
      chk("pwm stop", v, pin[0]);
    end
    // cascade as one 16-bit interval timer
    n = 256 + rnd() % 64;
    wr(0, MD, 8'h00);
    wr(1, MD, 8'h10);
    wr(1, CS, 8'h07);
    wr(0, CP, n[7:0]);
    wr(1, CP, n[15:8]);
    wr(1, MD, 8'h90);
    wr(0, MD, 8'h80);
    g = nhi;
    span(0, 1'h0, m);
    chk("cascade gap", n, m);
    chk("high irq idle", g, nhi);
    wr(0, MD, 8'h00);
    wr(1, MD, 8'h00);
    conclude();
  end
endmodule
